// *** shared/sfr_pkg.sv ***
// Constants and types shared by the serial flash command and read front end.
package sfr_pkg;

	// Array geometry: only the low address bits reach the array, the rest are ignored.
	localparam int ADDR_W = 19;
	localparam int ADDR_BITS = 24;
	localparam int CNT_W = 6;

	// Host side clock ceilings in MHz for the two single bit array reads.
	localparam int FAST_READ_CLOCK_LIMIT_MHZ = 85;
	localparam int SLOW_READ_CLOCK_LIMIT_MHZ = 50;

	// Phase lengths in link clocks; the status write limit is in bytes.
	localparam logic [5:0] DUMMY_BYTE_CLKS = 6'h08;
	localparam logic [5:0] DUMMY_3BYTE_CLKS = 6'h18;
	localparam logic [5:0] QUAD_IO_DUMMY_CLKS = 6'h04;
	localparam logic [5:0] DUAL_MODE_CLKS = 6'h04;
	localparam logic [5:0] QUAD_MODE_CLKS = 6'h02;
	localparam logic [5:0] BYTE_CLKS = 6'h08;
	localparam logic [5:0] CONT_RESET_DUAL_CLKS = 6'h08;
	localparam logic [5:0] CONT_RESET_QUAD_CLKS = 6'h02;
	localparam logic [1:0] STATUS_WRITE_MAX_BYTES = 2'h2;

	// Bit of the second status byte that allows the quad reads.
	localparam int QUAD_OUTPUT_ENABLE_BIT_POS = 1;
	// Mode byte bits 5:4 must read this value to keep continuous read mode.
	localparam logic [1:0] CONT_MODE_KEEP = 2'h2;

	// Opcodes.
	localparam logic [7:0] OP_READ_SLOW = 8'h03;
	localparam logic [7:0] OP_READ_FAST = 8'h0B;
	localparam logic [7:0] OP_READ_DUAL_OUT = 8'h3B;
	localparam logic [7:0] OP_READ_DUAL_IO = 8'hBB;
	localparam logic [7:0] OP_READ_QUAD_OUT = 8'h6B;
	localparam logic [7:0] OP_READ_QUAD_IO = 8'hEB;
	localparam logic [7:0] OP_CONT_RESET = 8'hFF;
	localparam logic [7:0] OP_ERASE_4K = 8'h20;
	localparam logic [7:0] OP_ERASE_32K = 8'h52;
	localparam logic [7:0] OP_ERASE_64K = 8'hD8;
	localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
	localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
	localparam logic [7:0] OP_PROGRAM = 8'h02;
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_VOL_STATUS_WREN = 8'h50;
	localparam logic [7:0] OP_SEC_ERASE = 8'h44;
	localparam logic [7:0] OP_SEC_PROGRAM = 8'h42;
	localparam logic [7:0] OP_SEC_READ = 8'h48;
	localparam logic [7:0] OP_STATUS1_READ = 8'h05;
	localparam logic [7:0] OP_STATUS2_READ = 8'h35;
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OP_JEDEC_ID = 8'h9F;
	localparam logic [7:0] OP_READ_ID = 8'h90;
	localparam logic [7:0] OP_POWER_DOWN = 8'hB9;
	localparam logic [7:0] OP_RESUME = 8'hAB;

	// Command phase of the link side sequencer.
	typedef enum logic [2:0] {PH_OPC, PH_ADDR, PH_MODE, PH_DUMMY, PH_OUT, PH_IN, PH_IGNORE}
		sfr_phase_e;

	// Source of the bytes shifted out in the output phase.
	typedef enum logic [2:0] {SRC_NONE, SRC_ARRAY, SRC_SEC, SRC_ST1, SRC_ST2, SRC_ID} sfr_src_e;

	// Shape of one command as decoded from its opcode.
	typedef struct packed {
		logic valid;
		logic has_addr;
		logic [2:0] aw;
		logic [5:0] mode_clks;
		logic [5:0] dummy_clks;
		sfr_src_e src;
		logic [2:0] ow;
		logic data_in;
	} sfr_attr_s;

	// Event handed from the link to the core.
	typedef enum logic {EVT_CMD, EVT_DATA} sfr_evt_e;

	typedef struct packed {
		sfr_evt_e kind;
		logic [7:0] opcode;
		logic [ADDR_W-1:0] addr;
		logic [7:0] data;
	} sfr_evt_s;

endpackage : sfr_pkg

// *** rtl/sfr_front_end.sv ***
// Serial flash slave front end: command decode, address capture and array read streaming.
module sfr_front_end #(
	parameter logic [7:0] MFR_ID = 8'h5A, // Arbitrary value.
	parameter logic [7:0] DEV_ID_HI = 8'hC3, // Arbitrary value.
	parameter logic [7:0] DEV_ID_LO = 8'h3C // Arbitrary value.
) (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic link_sck_i,
	input wire logic cs_n_i,
	input wire logic si_i,
	input wire logic so_i,
	input wire logic wp_n_i,
	input wire logic hold_n_i,
	input wire logic [7:0] array_data_i,
	input wire logic [7:0] status1_i,
	input wire logic [7:0] status2_i,
	output logic si_o,
	output logic si_oe_o,
	output logic so_o,
	output logic so_oe_o,
	output logic wp_n_o,
	output logic wp_n_oe_o,
	output logic hold_n_o,
	output logic hold_n_oe_o,
	output logic [sfr_pkg::ADDR_W-1:0] array_addr_o,
	output logic array_sec_o,
	output logic evt_valid_o,
	output sfr_pkg::sfr_evt_s evt_o,
	output logic link_busy_o
);

	// Shape of each supported opcode; quad reads are refused without the enable bit.
	function automatic sfr_pkg::sfr_attr_s decode(input logic [7:0] op, input logic qe);
		sfr_pkg::sfr_attr_s a;
		a = '0;
		a.aw = 3'h1;
		a.ow = 3'h1;
		a.src = sfr_pkg::SRC_NONE;
		case (op)
			sfr_pkg::OP_READ_SLOW, sfr_pkg::OP_READ_FAST:
			begin
				a.valid = 1'b1;
				a.has_addr = 1'b1;
				a.src = sfr_pkg::SRC_ARRAY;
				a.dummy_clks = (op == sfr_pkg::OP_READ_FAST) ? sfr_pkg::DUMMY_BYTE_CLKS : 6'h00;
			end
			sfr_pkg::OP_READ_DUAL_OUT, sfr_pkg::OP_READ_QUAD_OUT:
			begin
				a.valid = (op == sfr_pkg::OP_READ_DUAL_OUT) | qe;
				a.has_addr = 1'b1;
				a.src = sfr_pkg::SRC_ARRAY;
				a.dummy_clks = sfr_pkg::DUMMY_BYTE_CLKS;
				a.ow = (op == sfr_pkg::OP_READ_DUAL_OUT) ? 3'h2 : 3'h4;
			end
			sfr_pkg::OP_READ_DUAL_IO:
			begin
				a.valid = 1'b1;
				a.has_addr = 1'b1;
				a.src = sfr_pkg::SRC_ARRAY;
				a.aw = 3'h2;
				a.ow = 3'h2;
				a.mode_clks = sfr_pkg::DUAL_MODE_CLKS;
			end
			sfr_pkg::OP_READ_QUAD_IO:
			begin
				a.valid = qe;
				a.has_addr = 1'b1;
				a.src = sfr_pkg::SRC_ARRAY;
				a.aw = 3'h4;
				a.ow = 3'h4;
				a.mode_clks = sfr_pkg::QUAD_MODE_CLKS;
				a.dummy_clks = sfr_pkg::QUAD_IO_DUMMY_CLKS;
			end
			sfr_pkg::OP_ERASE_4K, sfr_pkg::OP_ERASE_32K, sfr_pkg::OP_ERASE_64K,
			sfr_pkg::OP_SEC_ERASE:
			begin
				a.valid = 1'b1;
				a.has_addr = 1'b1;
			end
			sfr_pkg::OP_PROGRAM, sfr_pkg::OP_SEC_PROGRAM:
			begin
				a.valid = 1'b1;
				a.has_addr = 1'b1;
				a.data_in = 1'b1;
			end
			sfr_pkg::OP_SEC_READ:
			begin
				a.valid = 1'b1;
				a.has_addr = 1'b1;
				a.src = sfr_pkg::SRC_SEC;
				a.dummy_clks = sfr_pkg::DUMMY_BYTE_CLKS;
			end
			sfr_pkg::OP_WRITE_ENABLE, sfr_pkg::OP_WRITE_DISABLE, sfr_pkg::OP_VOL_STATUS_WREN,
			sfr_pkg::OP_CHIP_ERASE_A, sfr_pkg::OP_CHIP_ERASE_B, sfr_pkg::OP_POWER_DOWN:
			begin
				a.valid = 1'b1;
			end
			sfr_pkg::OP_STATUS1_READ, sfr_pkg::OP_STATUS2_READ:
			begin
				a.valid = 1'b1;
				a.src = (op == sfr_pkg::OP_STATUS1_READ) ? sfr_pkg::SRC_ST1 : sfr_pkg::SRC_ST2;
			end
			sfr_pkg::OP_STATUS_WRITE:
			begin
				a.valid = 1'b1;
				a.data_in = 1'b1;
			end
			sfr_pkg::OP_JEDEC_ID:
			begin
				a.valid = 1'b1;
				a.src = sfr_pkg::SRC_ID;
			end
			sfr_pkg::OP_READ_ID, sfr_pkg::OP_RESUME:
			begin
				a.valid = 1'b1;
				a.src = sfr_pkg::SRC_ID;
				a.dummy_clks = sfr_pkg::DUMMY_3BYTE_CLKS;
			end
			default:
			begin
				a.valid = 1'b0;
			end
		endcase
		return a;
	endfunction : decode

	// Phase that follows a finished stage: 0 opcode, 1 address, 2 mode, 3 dummy.
	function automatic sfr_pkg::sfr_phase_e next_phase(input sfr_pkg::sfr_attr_s a,
		input logic [1:0] stage);
		sfr_pkg::sfr_phase_e p;
		if (stage == 2'h0 && a.has_addr)
			p = sfr_pkg::PH_ADDR;
		else if (stage <= 2'h1 && a.mode_clks != 6'h00)
			p = sfr_pkg::PH_MODE;
		else if (stage <= 2'h2 && a.dummy_clks != 6'h00)
			p = sfr_pkg::PH_DUMMY;
		else if (a.src != sfr_pkg::SRC_NONE)
			p = sfr_pkg::PH_OUT;
		else if (a.data_in)
			p = sfr_pkg::PH_IN;
		else
			p = sfr_pkg::PH_IGNORE;
		return p;
	endfunction : next_phase

	logic rst_meta_q;
	logic rst_n_sck_q;
	logic [15:0] stat_meta_q;
	logic [15:0] stat_sync_q;
	sfr_pkg::sfr_phase_e phase_q;
	logic [5:0] cnt_q;
	logic [7:0] op_q;
	logic [23:0] addr_q;
	logic [7:0] mode_q;
	logic [7:0] in_sh_q;
	logic [1:0] idx_q;
	logic sec_q;
	logic cont_q;
	logic [7:0] cont_op_q;
	logic pdown_q;
	logic tog_q;
	sfr_pkg::sfr_evt_s ev_q;
	logic [7:0] out_sh_q;
	logic tog_meta_q;
	logic tog_sync_q;
	logic tog_seen_q;
	logic cs_meta_q;
	logic cs_sync_q;

	// Status bytes are quasi-static core state, brought over by two flops per bit.
	always_ff @(posedge link_sck_i)
	begin
		rst_meta_q <= resetn_i;
		rst_n_sck_q <= rst_meta_q;
		stat_meta_q <= {status2_i, status1_i};
		stat_sync_q <= stat_meta_q;
	end

	wire quad_output_enable_bit = stat_sync_q[8 + sfr_pkg::QUAD_OUTPUT_ENABLE_BIT_POS];
	// In continuous read mode the first clocks of a frame already carry the address.
	wire cont_entry = (phase_q == sfr_pkg::PH_OPC) & cont_q;
	wire [7:0] cur_op = cont_entry ? cont_op_q : op_q;
	wire [7:0] op_full = {op_q[6:0], si_i};
	wire sfr_pkg::sfr_attr_s attr = decode(cur_op, quad_output_enable_bit);
	wire sfr_pkg::sfr_attr_s new_attr = decode(op_full, quad_output_enable_bit);
	wire in_addr = (phase_q == sfr_pkg::PH_ADDR) | cont_entry;

	// Input bits per clock: 1 on serial in, 2 on serial in and out, 4 on all pins.
	wire [2:0] in_w = (phase_q == sfr_pkg::PH_OPC && !cont_q) ? 3'h1 : attr.aw;
	wire [23:0] addr_shift = (in_w == 3'h4) ? {addr_q[19:0], hold_n_i, wp_n_i, so_i, si_i} :
		(in_w == 3'h2) ? {addr_q[21:0], so_i, si_i} : {addr_q[22:0], si_i};
	wire [7:0] mode_shift = (attr.aw == 3'h4) ? {mode_q[3:0], hold_n_i, wp_n_i, so_i, si_i} :
		(attr.aw == 3'h2) ? {mode_q[5:0], so_i, si_i} : {mode_q[6:0], si_i};
	wire [5:0] addr_clks = (attr.aw == 3'h4) ? 6'h06 : (attr.aw == 3'h2) ? 6'h0C : 6'h18;
	wire [5:0] byte_clks = (attr.ow == 3'h4) ? 6'h02 : (attr.ow == 3'h2) ? 6'h04 : 6'h08;
	wire [1:0] id_count = (cur_op == sfr_pkg::OP_JEDEC_ID) ? 2'h3 :
		(cur_op == sfr_pkg::OP_READ_ID) ? 2'h2 : 2'h1;
	wire [5:0] cnt_inc = cnt_q + 6'h01;

	// End of each stage in the current clock.
	wire opc_done = (phase_q == sfr_pkg::PH_OPC) & !cont_q & (cnt_q == 6'h07);
	wire addr_done = in_addr & (cnt_q == addr_clks - 6'h01);
	wire mode_done = (phase_q == sfr_pkg::PH_MODE) & (cnt_q == attr.mode_clks - 6'h01);
	wire dummy_done = (phase_q == sfr_pkg::PH_DUMMY) & (cnt_q == attr.dummy_clks - 6'h01);
	wire out_done = (phase_q == sfr_pkg::PH_OUT) & (cnt_q == byte_clks - 6'h01);
	wire in_done = (phase_q == sfr_pkg::PH_IN) & (cnt_q == sfr_pkg::BYTE_CLKS - 6'h01);

	// An all ones lead-in while in continuous mode is the mode reset, not an address.
	wire cont_rst_seq = cont_q & in_addr & (((attr.aw == 3'h2) &
		(cnt_q == sfr_pkg::CONT_RESET_DUAL_CLKS - 6'h01) & (&addr_shift[15:0])) |
		((attr.aw == 3'h4) & (cnt_q == sfr_pkg::CONT_RESET_QUAD_CLKS - 6'h01) &
		(&addr_shift[7:0])));
	wire opc_refuse = opc_done & (!new_attr.valid | (pdown_q & op_full != sfr_pkg::OP_RESUME));
	wire opc_ok = opc_done & !opc_refuse;

	// Non-read commands announce themselves once their opcode and address are complete.
	wire cmd_fire = (opc_ok & ((!new_attr.has_addr & new_attr.src == sfr_pkg::SRC_NONE) |
		(op_full == sfr_pkg::OP_RESUME))) | (addr_done & !cont_rst_seq &
		attr.src == sfr_pkg::SRC_NONE);
	wire ev_fire = cmd_fire | in_done;
	wire sfr_pkg::sfr_evt_s ev_d = '{kind: in_done ? sfr_pkg::EVT_DATA : sfr_pkg::EVT_CMD,
		opcode: opc_done ? op_full : cur_op,
		addr: addr_done ? addr_shift[sfr_pkg::ADDR_W-1:0] : addr_q[sfr_pkg::ADDR_W-1:0],
		data: {in_sh_q[6:0], si_i}};

	// Link sequencer: deselect clears everything, so each frame starts at the opcode, or at the address in continuous read mode.
	always_ff @(posedge link_sck_i or posedge cs_n_i)
	begin
		if (cs_n_i)
		begin
			phase_q <= sfr_pkg::PH_OPC;
			cnt_q <= 6'h00;
			op_q <= 8'h00;
			addr_q <= 24'h000000;
			mode_q <= 8'h00;
			in_sh_q <= 8'h00;
			idx_q <= 2'h0;
			sec_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_inc;
			case (phase_q)
				sfr_pkg::PH_OPC:
				begin
					if (cont_q)
					begin
						op_q <= cont_op_q;
						addr_q <= addr_shift;
						phase_q <= sfr_pkg::PH_ADDR;
					end
					else
					begin
						op_q <= op_full;
						sec_q <= (op_full == sfr_pkg::OP_SEC_READ);
						if (opc_done)
						begin
							cnt_q <= 6'h00;
							phase_q <= opc_ok ? next_phase(new_attr, 2'h0) :
								sfr_pkg::PH_IGNORE;
						end
					end
				end
				sfr_pkg::PH_ADDR:
				begin
					addr_q <= addr_shift;
					if (cont_rst_seq)
						phase_q <= sfr_pkg::PH_IGNORE;
					else if (addr_done)
					begin
						cnt_q <= 6'h00;
						phase_q <= next_phase(attr, 2'h1);
					end
				end
				sfr_pkg::PH_MODE:
				begin
					mode_q <= mode_shift;
					if (mode_done)
					begin
						cnt_q <= 6'h00;
						phase_q <= next_phase(attr, 2'h2);
					end
				end
				sfr_pkg::PH_DUMMY:
				begin
					if (dummy_done)
					begin
						cnt_q <= 6'h00;
						phase_q <= next_phase(attr, 2'h3);
					end
				end
				sfr_pkg::PH_OUT:
				begin
					if (out_done)
					begin
						cnt_q <= 6'h00;
						// The counter runs over the array bits only, so it wraps to zero.
						addr_q <= {5'h00, addr_q[sfr_pkg::ADDR_W-1:0] + 19'h00001};
						idx_q <= (idx_q + 2'h1 == id_count) ? 2'h0 : idx_q + 2'h1;
					end
				end
				sfr_pkg::PH_IN:
				begin
					in_sh_q <= {in_sh_q[6:0], si_i};
					if (in_done)
					begin
						cnt_q <= 6'h00;
						idx_q <= idx_q + 2'h1;
						if (cur_op == sfr_pkg::OP_STATUS_WRITE &&
							idx_q + 2'h1 == sfr_pkg::STATUS_WRITE_MAX_BYTES)
							phase_q <= sfr_pkg::PH_IGNORE;
					end
				end
				sfr_pkg::PH_IGNORE:
				begin
					cnt_q <= 6'h00;
				end
				default:
				begin
					phase_q <= sfr_pkg::PH_IGNORE;
				end
			endcase
		end
	end

	// State that outlives a frame: continuous read mode, power down and the event word.
	always_ff @(posedge link_sck_i)
	begin
		if (!rst_n_sck_q)
		begin
			cont_q <= 1'b0;
			cont_op_q <= 8'h00;
			pdown_q <= 1'b0;
			tog_q <= 1'b0;
			ev_q <= '0;
		end
		else if (!cs_n_i)
		begin
			if (cont_rst_seq || (opc_done && op_full == sfr_pkg::OP_CONT_RESET))
				cont_q <= 1'b0;
			else if (mode_done)
			begin
				cont_q <= (mode_shift[5:4] == sfr_pkg::CONT_MODE_KEEP);
				cont_op_q <= cur_op;
			end
			if (opc_ok && op_full == sfr_pkg::OP_POWER_DOWN)
				pdown_q <= 1'b1;
			else if (opc_ok && op_full == sfr_pkg::OP_RESUME)
				pdown_q <= 1'b0;
			if (ev_fire)
			begin
				tog_q <= ~tog_q;
				ev_q <= ev_d;
			end
		end
	end

	// Byte source for the output phase.
	wire [7:0] id_byte = (cur_op == sfr_pkg::OP_RESUME) ? DEV_ID_LO :
		(idx_q == 2'h0) ? MFR_ID : (idx_q == 2'h1) ? DEV_ID_HI : DEV_ID_LO;
	wire [7:0] src_byte = (attr.src == sfr_pkg::SRC_ST1) ? stat_sync_q[7:0] :
		(attr.src == sfr_pkg::SRC_ST2) ? stat_sync_q[15:8] :
		(attr.src == sfr_pkg::SRC_ID) ? id_byte : array_data_i;
	wire [7:0] cur_byte = (cnt_q == 6'h00) ? src_byte : out_sh_q;
	wire [7:0] next_sh = (attr.ow == 3'h4) ? {cur_byte[3:0], 4'h0} :
		(attr.ow == 3'h2) ? {cur_byte[5:0], 2'h0} : {cur_byte[6:0], 1'b0};
	wire drive = (phase_q == sfr_pkg::PH_OUT);
	wire quad = (attr.ow == 3'h4);
	wire dual = (attr.ow == 3'h2);
	// Pin mapping: most significant bit on serial out, or on the highest pin in quad.
	wire so_d = quad ? cur_byte[5] : cur_byte[7];
	wire si_d = quad ? cur_byte[4] : cur_byte[6];
	wire wp_d = cur_byte[6];
	wire hold_d = cur_byte[7];

	// Output pins change on the falling edge; a mode 3 leading fall finds no output phase.
	always_ff @(negedge link_sck_i or posedge cs_n_i)
	begin
		if (cs_n_i)
		begin
			out_sh_q <= 8'h00;
			so_o <= 1'b0;
			si_o <= 1'b0;
			wp_n_o <= 1'b0;
			hold_n_o <= 1'b0;
			so_oe_o <= 1'b0;
			si_oe_o <= 1'b0;
			wp_n_oe_o <= 1'b0;
			hold_n_oe_o <= 1'b0;
		end
		else
		begin
			out_sh_q <= next_sh;
			so_o <= so_d;
			si_o <= si_d;
			wp_n_o <= wp_d;
			hold_n_o <= hold_d;
			so_oe_o <= drive;
			si_oe_o <= drive & (dual | quad);
			wp_n_oe_o <= drive & quad;
			hold_n_oe_o <= drive & quad;
		end
	end

	assign array_addr_o = addr_q[sfr_pkg::ADDR_W-1:0];
	assign array_sec_o = sec_q;

	// Core side: the event toggle and select are synchronised before anything reads them.
	always_ff @(posedge ref_clk_i)
	begin
		if (!resetn_i)
		begin
			tog_meta_q <= 1'b0;
			tog_sync_q <= 1'b0;
			tog_seen_q <= 1'b0;
			cs_meta_q <= 1'b1;
			cs_sync_q <= 1'b1;
			link_busy_o <= 1'b0;
			evt_valid_o <= 1'b0;
			evt_o <= '0;
		end
		else
		begin
			tog_meta_q <= tog_q;
			tog_sync_q <= tog_meta_q;
			tog_seen_q <= tog_sync_q;
			cs_meta_q <= cs_n_i;
			cs_sync_q <= cs_meta_q;
			link_busy_o <= !cs_sync_q;
			evt_valid_o <= tog_sync_q ^ tog_seen_q;
			if (tog_sync_q ^ tog_seen_q)
				evt_o <= ev_q;
		end
	end

endmodule : sfr_front_end

// *** sim/sfr_front_end_props.sv ***
// Concurrent checks on the ports of the serial flash front end.
module sfr_front_end_props (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic link_sck_i,
	input wire logic cs_n_i,
	input wire logic [7:0] status2_i,
	input wire logic si_oe_o,
	input wire logic so_oe_o,
	input wire logic wp_n_oe_o,
	input wire logic hold_n_oe_o,
	input wire logic [sfr_pkg::ADDR_W-1:0] array_addr_o,
	input wire logic evt_valid_o,
	input wire sfr_pkg::sfr_evt_s evt_o,
	input wire logic link_busy_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] rise_cnt_q;

	// Counts serial clock rises of the current frame; deselect clears it at once.
	always_ff @(posedge link_sck_i or posedge cs_n_i)
	begin
		if (cs_n_i)
			rise_cnt_q <= 6'h00;
		else if (rise_cnt_q != 6'h3F)
			rise_cnt_q <= rise_cnt_q + 6'h01;
	end

	// Pin enables, frame timing and core events.
	chk_pins_float: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		cs_n_i |-> !(si_oe_o || so_oe_o || wp_n_oe_o || hold_n_oe_o))
		else $error("pin driven while deselected");
	chk_quad_group: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		(wp_n_oe_o || hold_n_oe_o) |-> (wp_n_oe_o && hold_n_oe_o && so_oe_o && si_oe_o))
		else $error("quad pins not driven together");
	chk_dual_pair: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		si_oe_o |-> so_oe_o)
		else $error("serial in driven without serial out");
	chk_quad_gate: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		$rose(wp_n_oe_o) |-> status2_i[1])
		else $error("quad output without quad enable");
	chk_oe_late: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		so_oe_o |-> rise_cnt_q >= 6'h08)
		else $error("output before opcode complete");
	chk_addr_step: assert property (@(posedge link_sck_i) disable iff (cs_n_i || !resetn_i)
		so_oe_o && $past(so_oe_o) && $changed(array_addr_o)
		|-> array_addr_o == $past(array_addr_o) + 19'h00001)
		else $error("address counter did not step by one");
	chk_cmd_known: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		evt_valid_o && evt_o.kind == sfr_pkg::EVT_CMD |-> evt_o.opcode inside {8'h06, 8'h04,
		8'h50, 8'h60, 8'hC7, 8'h20, 8'h52, 8'hD8, 8'h02, 8'h44, 8'h42, 8'h01, 8'hB9, 8'hAB})
		else $error("event for unsupported opcode");
	chk_evt_single: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		evt_valid_o |=> !evt_valid_o)
		else $error("event pulse longer than one cycle");
	chk_busy_on: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		$fell(cs_n_i) |-> ##[1:6] link_busy_o)
		else $error("busy did not follow select");
	chk_busy_off: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		$rose(cs_n_i) |-> ##[1:6] !link_busy_o)
		else $error("busy did not follow deselect");
endmodule : sfr_front_end_props

bind sfr_front_end sfr_front_end_props u_sfr_front_end_props (.ref_clk_i, .resetn_i,
	.link_sck_i, .cs_n_i, .status2_i, .si_oe_o, .so_oe_o, .wp_n_oe_o, .hold_n_oe_o,
	.array_addr_o, .evt_valid_o, .evt_o, .link_busy_o);

// *** sim/sfr_hm.sv ***
// Host serial master model that owns the link clock, select and shared data lines.
module sfr_hm (
	output logic sck_o,
	output logic cs_n_o,
	output logic [3:0] io_o,
	input wire logic [3:0] dev_io_i,
	input wire logic [3:0] dev_oe_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] drv = 4'hC;
	logic [3:0] en = 4'hD;
	logic patt = 1'b0;
	logic cpol = 1'b0;

	// Device wins while driving; a line nobody drives toggles every clock.
	assign io_o = (dev_oe_i & dev_io_i) | (~dev_oe_i & ((en & drv) | (~en & {4{patt}})));

	initial
	begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
	end

	// Clocks the link during reset with select held high.
	task automatic pulse(input int n);
		repeat (n)
		begin
			#4 sck_o = 1'b1;
			#4 sck_o = 1'b0;
		end
	endtask : pulse

	// Selects the device with the clock resting at the mode's idle level.
	task automatic open(input logic mode3);
		cpol = mode3;
		sck_o = mode3;
		#40 cs_n_o = 1'b0;
		#40;
	endtask : open

	// One clock: data changes after the fall, lines are sampled at the rise.
	task automatic tick(input logic [3:0] d, output logic [3:0] s);
		sck_o = 1'b0;
		drv = d;
		patt = ~patt;
		#32 s = io_o;
		sck_o = 1'b1;
		#32;
	endtask : tick

	// Shifts n clocks of w bits each, most significant first.
	task automatic send(input logic [31:0] v, input int n, input int w);
		logic [3:0] s;
		en = (w == 1) ? 4'hD : 4'hF;
		for (int i = n - 1; i >= 0; i--)
			tick((w == 1) ? {3'h6, v[i]} : (w == 2) ? {2'h3, v[2*i+1 -: 2]} : v[4*i+3 -: 4], s);
	endtask : send

	// Releases the data lines of width w and collects n clocks of answer.
	task automatic recv(input int n, input int w, output logic [31:0] rx);
		logic [3:0] s;
		en = (w == 1) ? 4'hD : (w == 2) ? 4'hC : 4'h0;
		rx = '0;
		for (int i = 0; i < n; i++)
		begin
			tick(drv, s);
			rx = (w == 1) ? {rx[30:0], s[1]} : (w == 2) ? {rx[29:0], s[1:0]} : {rx[27:0], s};
		end
	endtask : recv

	// Ends the frame; the clock returns to its idle level before deselect.
	task automatic close();
		if (!cpol)
			sck_o = 1'b0;
		#40 cs_n_o = 1'b1;
		en = 4'hD;
		#200;
	endtask : close
endmodule : sfr_hm

// *** sim/sfr_front_end_tb.sv ***
// Self-checking bench for the serial flash front end.
module sfr_front_end_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] MFR = 8'h5A; // Arbitrary value.
	localparam logic [7:0] DHI = 8'hC3; // Arbitrary value.
	localparam logic [7:0] DLO = 8'h3C; // Arbitrary value.
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic sck, cs_n, asec, evv, busy;
	logic [3:0] io, dout, doe;
	logic [7:0] st1 = 8'h00;
	logic [7:0] st2 = 8'h02;
	logic [7:0] adata;
	logic [18:0] aaddr;
	logic [31:0] rx;
	sfr_pkg::sfr_evt_s evt;
	sfr_pkg::sfr_evt_s evq[$];
	int n_errors = 0;
	int comparisons = 0;
	logic cfr = 1'b0;
	logic [7:0] mbyte = 8'h00;
	logic [7:0] rops [7] = '{8'h03, 8'h0B, 8'h3B, 8'hBB, 8'h6B, 8'hEB, 8'h48};
	logic [7:0] cops [13] = '{8'h06, 8'h04, 8'h50, 8'h60, 8'hC7, 8'h20, 8'h52, 8'hD8,
		8'h44, 8'h02, 8'h42, 8'h01, 8'hB9};

	always #2.5 ref_clk = ~ref_clk;

	// Array content follows from the address and the security page select.
	function automatic logic [7:0] mem(input logic [18:0] a, input logic s);
		return a[7:0] ^ {a[18:12], s} ^ 8'hA5;
	endfunction : mem
	assign adata = mem(aaddr, asec);

	// Core events are queued as they arrive.
	always @(negedge ref_clk)
		if (evv === 1'b1)
			evq.push_back(evt);

	sfr_front_end #(.MFR_ID(MFR), .DEV_ID_HI(DHI), .DEV_ID_LO(DLO)) u_sfr_front_end (
		.ref_clk_i(ref_clk), .resetn_i(resetn), .link_sck_i(sck), .cs_n_i(cs_n),
		.si_i(io[0]), .so_i(io[1]), .wp_n_i(io[2]), .hold_n_i(io[3]),
		.array_data_i(adata), .status1_i(st1), .status2_i(st2),
		.si_o(dout[0]), .si_oe_o(doe[0]), .so_o(dout[1]), .so_oe_o(doe[1]),
		.wp_n_o(dout[2]), .wp_n_oe_o(doe[2]), .hold_n_o(dout[3]), .hold_n_oe_o(doe[3]),
		.array_addr_o(aaddr), .array_sec_o(asec), .evt_valid_o(evv), .evt_o(evt),
		.link_busy_o(busy));
	sfr_hm u_sfr_hm (.sck_o(sck), .cs_n_o(cs_n), .io_o(io), .dev_io_i(dout), .dev_oe_i(doe));

	// Compares one value and reports a mismatch at once.
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	// Opens a frame in a random clock mode and sends the opcode.
	task automatic hdr(input logic [7:0] op);
		u_sfr_hm.open(1'($urandom_range(1)));
		u_sfr_hm.send({24'h0, op}, 8, 1);
	endtask : hdr

	// One read frame ending mid-byte; every streamed byte is compared.
	task automatic rd(input logic [7:0] op, input logic [23:0] a, input int nb, input logic ok);
		int aw;
		int w;
		int dc;
		logic [18:0] ai;
		aw = (op == 8'hBB) ? 2 : (op == 8'hEB) ? 4 : 1;
		w = (op == 8'h3B || op == 8'hBB) ? 2 : (op == 8'h6B || op == 8'hEB) ? 4 : 1;
		dc = (op == 8'h03) ? 0 : (op == 8'hBB) ? 4 : (op == 8'hEB) ? 6 : 8;
		ai = a[18:0];
		if (cfr)
			u_sfr_hm.open(1'($urandom_range(1)));
		else
			hdr(op);
		u_sfr_hm.send({8'h0, a}, 24 / aw, aw);
		u_sfr_hm.send({24'h0, mbyte}, dc, aw);
		for (int i = 0; i < nb; i++)
		begin
			u_sfr_hm.recv(8 / w, w, rx);
			if (ok)
				check(rx[7:0], mem(ai, op == 8'h48), "read byte");
			else
				check(doe, 4'h0, "refused pins");
			ai = ai + 19'h00001;
		end
		u_sfr_hm.recv(3, 1, rx);
		u_sfr_hm.close();
		check(doe, 4'h0, "pins after deselect");
	endtask : rd

	// Takes the oldest event and compares it.
	task automatic expev(input logic k, input logic [7:0] op, input logic [18:0] a,
		input logic [7:0] d);
		sfr_pkg::sfr_evt_s e;
		e = '1;
		if (evq.size() > 0)
			e = evq.pop_front();
		check(e.kind, k, "event kind");
		if (k)
			check(e.data, d, "event data");
		else
			check({e.opcode, 5'h00, e.addr}, {op, 5'h00, a}, "event command");
	endtask : expev

	// Sends a command with its address and data bytes and checks its events.
	task automatic cmd(input logic [7:0] op);
		logic [23:0] a;
		logic [7:0] d [2];
		int nd;
		a = 24'($urandom);
		nd = (op == 8'h02 || op == 8'h42 || op == 8'h01) ? 2 : 0;
		hdr(op);
		if (op inside {8'h20, 8'h52, 8'hD8, 8'h44, 8'h02, 8'h42})
			u_sfr_hm.send({8'h0, a}, 24, 1);
		else
			a = 24'h0;
		for (int i = 0; i < nd; i++)
		begin
			d[i] = 8'($urandom);
			u_sfr_hm.send({24'h0, d[i]}, 8, 1);
		end
		u_sfr_hm.close();
		expev(1'b0, op, a[18:0], 8'h00);
		for (int i = 0; i < nd; i++)
			expev(1'b1, op, 19'h0, d[i]);
		check(evq.size(), 0, "extra event");
	endtask : cmd

	// Reads status or identification bytes after the given dummy clocks.
	task automatic idr(input logic [7:0] op, input int dclk, input int nb, input logic [31:0] exp);
		hdr(op);
		u_sfr_hm.send(32'h0, dclk, 1);
		u_sfr_hm.recv(8 * nb, 1, rx);
		u_sfr_hm.close();
		check(rx, exp, "status or id");
		evq.delete();
	endtask : idr

	// Prints the counts and the verdict, then stops.
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run

	// Cuts a hung run short.
	initial
	begin
		#400000;
		n_errors++;
		$display("wrong value at %0t: run did not finish", $time);
		complete_run();
	end

	// Main sequence.
	initial
	begin
		void'($urandom(32'hDDC8));
		st1 = 8'($urandom);
		fork
			u_sfr_hm.pulse(4);
			repeat (8) @(negedge ref_clk);
		join
		resetn = 1'b1;
		#200;
		foreach (rops[i])
			rd(rops[i], 24'($urandom), 1 + $urandom_range(4), 1'b1);
		rd(8'h03, 24'hFFFFFE, 4, 1'b1);
		rd(8'hEB, 24'hF7FFFF, 3, 1'b1);
		// Mode bits 10 keep continuous mode; the next frame starts with its address.
		mbyte = 8'h20;
		rd(8'hBB, {1'b0, 23'($urandom)}, 2, 1'b1);
		cfr = 1'b1;
		rd(8'hBB, {1'b0, 23'($urandom)}, 2, 1'b1);
		u_sfr_hm.open(1'b0);
		u_sfr_hm.send(32'h0000FFFF, 8, 2);
		u_sfr_hm.close();
		cfr = 1'b0;
		mbyte = 8'h00;
		rd(8'h03, 24'($urandom), 2, 1'b1);
		$display("test array reads finished");
		@(negedge ref_clk);
		st2 = 8'hFD & 8'($urandom);
		rd(8'h6B, 24'($urandom), 2, 1'b0);
		rd(8'hEB, 24'($urandom), 2, 1'b0);
		rd(8'h77, 24'($urandom), 2, 1'b0);
		@(negedge ref_clk);
		st2 = 8'h02 | 8'($urandom);
		hdr(8'h03);
		u_sfr_hm.send(32'h0, 12, 1);
		u_sfr_hm.close();
		hdr(8'h52);
		u_sfr_hm.send(32'h0, 20, 1);
		u_sfr_hm.close();
		check(evq.size(), 0, "stray event");
		rd(8'h03, 24'($urandom), 2, 1'b1);
		$display("test refusals finished");
		foreach (cops[i])
			cmd(cops[i]);
		rd(8'h03, 24'($urandom), 1, 1'b0);
		check(evq.size(), 0, "event in power down");
		cmd(8'hAB);
		idr(8'hAB, 24, 2, {16'h0, DLO, DLO});
		idr(8'h05, 0, 2, {16'h0, st1, st1});
		idr(8'h35, 0, 1, {24'h0, st2});
		idr(8'h9F, 0, 4, {MFR, DHI, DLO, MFR});
		idr(8'h90, 24, 3, {8'h0, MFR, DHI, MFR});
		$display("test commands finished");
		complete_run();
	end
endmodule : sfr_front_end_tb
